// ### design/acem_top.v
/*
 * Audio clock error monitor: checks frame, bit and system clocks against one another,
 * watches PLL lock, and holds the detector ignore control register behind an APB slave.
 * Assumes all pin inputs are synchronous to clk_in and sampled as plain levels.
 */
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "acem_defines.vh"

// What this block does
// - A sample-rate fault raises clock error while the rate ignore bit is 0, and also sets the bit-clock and system-clock ratio faults.
// - A bit-clock fault is reported unless the bit clock is stable at 32 to 256 edges per frame.
// - A bit-clock fault raises clock error only while the bit-clock ignore bit is 0.
// - A system-clock fault is flagged unless edges per frame match an allowed ratio within a margin.
// - A system-clock ratio fault raises clock error only while its ignore bit is 0.
// - A static or too slow system clock is a halt that raises clock error unless its ignore bit is 1.
// - Frame and bit clocks count as missing only when both are held low, not when held high.
// - Missing clocks force powerdown while the missing ignore bit is 0 and leave powerdown low when it is 1.
// - The autoset disable bit at 0 derives dividers automatically and at 1 uses the manual values.
// - Loss of PLL lock raises clock error only while the PLL ignore bit is 0.
// - The lock flag at bit 4 of the status register always shows the true lock state.
// - After reset all seven control bits read 0, so all detectors and autoset are on.
// - While autoset is on, the manual speed selection and frame cycle count are disregarded.
module acem_top #(
	parameter NRAT = 4,
	parameter [39:0] SYS_RATIOS = {10'd256, 10'd192, 10'd128, 10'd64},
	parameter RW = 10,
	parameter PW = 16
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire frame_clock_in,
	input wire bit_clock_in,
	input wire sys_clock_in,
	input wire pll_locked_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	output reg clock_error_out,
	output reg powerdown_out,
	output reg autoset_active_out,
	output reg [1:0] speed_sel_out,
	output reg [15:0] frame_cycles_out
);

	// ****************************************************************
	// Timing counts.
	// ****************************************************************
	localparam integer FRAME_MIN = `ACEM_CLK_HZ / `ACEM_FS_MAX_HZ;
	localparam integer FRAME_MAX = `ACEM_CLK_HZ / `ACEM_FS_MIN_HZ;
	localparam integer P_SINGLE = `ACEM_CLK_HZ / `ACEM_FS_SINGLE_HZ;
	localparam integer P_DOUBLE = `ACEM_CLK_HZ / `ACEM_FS_DOUBLE_HZ;
	localparam integer P_QUAD = `ACEM_CLK_HZ / `ACEM_FS_QUAD_HZ;
	localparam integer HALT_CYC = (`ACEM_HALT_TIME_NS + `ACEM_CLK_PERIOD_NS - 1) / `ACEM_CLK_PERIOD_NS;
	localparam integer MISS_CYC = (`ACEM_MISSING_TIME_NS + `ACEM_CLK_PERIOD_NS - 1) / `ACEM_CLK_PERIOD_NS;
	localparam [RW-1:0] BCK_MIN = `ACEM_BCK_RATIO_MIN;
	localparam [RW-1:0] BCK_MAX = `ACEM_BCK_RATIO_MAX;
	localparam [RW-1:0] TOL = `ACEM_RATIO_TOL;

	// ****************************************************************
	// Register state.
	// ****************************************************************
	reg [6:0] ctrl_q;
	reg [1:0] speed_q;
	reg [15:0] cycles_q;
	reg pready_q;
	wire [7:0] idx;
	wire addr_ok;
	wire wr_go;
	wire rd_go;

	wire ign_rate;
	wire ign_bitclk;
	wire ign_sysratio;
	wire ign_halt;
	wire ign_missing;
	wire autoset_dis;
	wire ign_pll;

	assign ign_rate = ctrl_q[`ACEM_BIT_IGN_RATE];
	assign ign_bitclk = ctrl_q[`ACEM_BIT_IGN_BITCLK];
	assign ign_sysratio = ctrl_q[`ACEM_BIT_IGN_SYSRATIO];
	assign ign_halt = ctrl_q[`ACEM_BIT_IGN_HALT];
	assign ign_missing = ctrl_q[`ACEM_BIT_IGN_MISSING];
	assign autoset_dis = ctrl_q[`ACEM_BIT_AUTOSET_DIS];
	assign ign_pll = ctrl_q[`ACEM_BIT_IGN_PLL];

	// ****************************************************************
	// Frame clock period measurement.
	// ****************************************************************
	reg frame_q;
	reg [PW-1:0] period_cnt_q;
	reg [PW-1:0] period_q;
	reg period_valid_q;
	wire frame_edge;

	assign frame_edge = frame_clock_in & ~frame_q;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_q <= 1'b0;
			period_cnt_q <= {PW{1'b0}};
			period_q <= {PW{1'b0}};
			period_valid_q <= 1'b0;
		end else begin
			frame_q <= frame_clock_in;
			if (frame_edge) begin
				period_cnt_q <= {{(PW-1){1'b0}}, 1'b1};
				period_q <= period_cnt_q;
				period_valid_q <= 1'b1;
			end else if (period_cnt_q != {PW{1'b1}}) begin
				period_cnt_q <= period_cnt_q + {{(PW-1){1'b0}}, 1'b1};
			end
		end
	end

	// ****************************************************************
	// Edge counters against the frame clock.
	// ****************************************************************
	wire [RW-1:0] bck_count;
	wire bck_done;
	wire [RW-1:0] sck_count;
	wire sck_done;

	acem_ratio_meter #(
		.W(RW)
	) u_bck_meter (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.frame_edge_in(frame_edge),
		.sig_in(bit_clock_in),
		.count_out(bck_count),
		.done_out(bck_done)
	);

	acem_ratio_meter #(
		.W(RW)
	) u_sck_meter (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.frame_edge_in(frame_edge),
		.sig_in(sys_clock_in),
		.count_out(sck_count),
		.done_out(sck_done)
	);

	// ****************************************************************
	// Halt and missing clock detectors.
	// ****************************************************************
	reg sys_q;
	wire halt_det;
	wire missing_det;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sys_q <= 1'b0;
		end else begin
			sys_q <= sys_clock_in;
		end
	end

	acem_idle_timer #(
		.LIMIT(HALT_CYC),
		.W(12)
	) u_halt (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.cond_in(sys_clock_in == sys_q),
		.idle_out(halt_det)
	);

	acem_idle_timer #(
		.LIMIT(MISS_CYC),
		.W(12)
	) u_missing (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.cond_in(~frame_clock_in & ~bit_clock_in),
		.idle_out(missing_det)
	);

	// ****************************************************************
	// Fault evaluation.
	// ****************************************************************
	reg rate_flt_q;
	reg bck_flt_q;
	reg sck_flt_q;
	reg unlock_q;
	reg [RW-1:0] bck_prev_q;
	wire [RW-1:0] bck_diff;
	wire [NRAT-1:0] ratio_hit;

	assign bck_diff = (bck_count > bck_prev_q) ? (bck_count - bck_prev_q) : (bck_prev_q - bck_count);

	genvar gi;
	generate
		for (gi = 0; gi < NRAT; gi = gi + 1) begin : g_ratio
			wire [RW-1:0] r;
			assign r = SYS_RATIOS[gi*10 +: 10];
			assign ratio_hit[gi] = (sck_count + TOL >= r) && (sck_count <= r + TOL);
		end
	endgenerate

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rate_flt_q <= 1'b0;
			bck_flt_q <= 1'b0;
			sck_flt_q <= 1'b0;
			unlock_q <= 1'b0;
			bck_prev_q <= {RW{1'b0}};
		end else begin
			unlock_q <= ~pll_locked_in;
			if (period_cnt_q > FRAME_MAX[PW-1:0]) begin
				rate_flt_q <= 1'b1;
			end else if (frame_edge) begin
				rate_flt_q <= (period_cnt_q < FRAME_MIN[PW-1:0]);
			end
			if (rate_flt_q) begin
				bck_flt_q <= 1'b1;
				sck_flt_q <= 1'b1;
			end else begin
				if (bck_done) begin
					bck_prev_q <= bck_count;
					bck_flt_q <= (bck_count < BCK_MIN) || (bck_count > BCK_MAX) || (bck_diff > TOL);
				end
				if (sck_done) begin
					sck_flt_q <= ~|ratio_hit;
				end
			end
		end
	end

	// ****************************************************************
	// Automatic divider derivation.
	// ****************************************************************
	reg [1:0] auto_speed;
	wire [15:0] auto_cycles;

	assign auto_cycles = period_valid_q ? period_q[15:0] : `ACEM_RST_CYC;

	always @* begin
		if (period_q >= P_SINGLE[PW-1:0]) begin
			auto_speed = 2'h0;
		end else if (period_q >= P_DOUBLE[PW-1:0]) begin
			auto_speed = 2'h1;
		end else if (period_q >= P_QUAD[PW-1:0]) begin
			auto_speed = 2'h2;
		end else begin
			auto_speed = 2'h3;
		end
	end

	// ****************************************************************
	// Outputs.
	// ****************************************************************
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clock_error_out <= 1'b0;
			powerdown_out <= 1'b0;
			autoset_active_out <= 1'b1;
			speed_sel_out <= `ACEM_RST_SPEED;
			frame_cycles_out <= `ACEM_RST_CYC;
		end else begin
			clock_error_out <= (rate_flt_q & ~ign_rate) |
				(bck_flt_q & ~ign_bitclk) |
				(sck_flt_q & ~ign_sysratio) |
				(halt_det & ~ign_halt) |
				(unlock_q & ~ign_pll);
			powerdown_out <= missing_det & ~ign_missing;
			autoset_active_out <= ~autoset_dis;
			if (autoset_dis) begin
				speed_sel_out <= speed_q;
				frame_cycles_out <= cycles_q;
			end else begin
				speed_sel_out <= auto_speed;
				frame_cycles_out <= auto_cycles;
			end
		end
	end

	// ****************************************************************
	// APB slave.
	// ****************************************************************
	assign idx = paddr_in[9:2];
	assign addr_ok = (paddr_in[1:0] == 2'h0) && (paddr_in[11:10] == 2'h0) &&
		((idx == `ACEM_IDX_STATUS) || (idx == `ACEM_IDX_SPEED) || (idx == `ACEM_IDX_CYC_MSB) ||
		(idx == `ACEM_IDX_CYC_LSB) || (idx == `ACEM_IDX_CTRL) || (idx == `ACEM_IDX_FAULT));
	assign rd_go = psel_in & penable_in & ~pready_q;
	assign wr_go = psel_in & penable_in & pready_q & pwrite_in & addr_ok;

	reg [31:0] rdata;

	always @* begin
		rdata = 32'h00000000;
		case (idx)
			`ACEM_IDX_STATUS: begin
				rdata[`ACEM_BIT_PLL_LOCK] = pll_locked_in;
			end
			`ACEM_IDX_SPEED: begin
				rdata[1:0] = speed_q;
			end
			`ACEM_IDX_CYC_MSB: begin
				rdata[7:0] = cycles_q[15:8];
			end
			`ACEM_IDX_CYC_LSB: begin
				rdata[7:0] = cycles_q[7:0];
			end
			`ACEM_IDX_CTRL: begin
				rdata[6:0] = ctrl_q;
			end
			`ACEM_IDX_FAULT: begin
				rdata[6:0] = {clock_error_out, unlock_q, missing_det, halt_det, sck_flt_q, bck_flt_q, rate_flt_q};
			end
			default: begin
				rdata = 32'h00000000;
			end
		endcase
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl_q <= `ACEM_RST_CTRL;
			speed_q <= `ACEM_RST_SPEED;
			cycles_q <= `ACEM_RST_CYC;
			pready_q <= 1'b0;
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h00000000;
		end else begin
			pready_q <= rd_go;
			pready_out <= rd_go;
			pslverr_out <= rd_go & ~addr_ok;
			if (rd_go) begin
				prdata_out <= (addr_ok && !pwrite_in) ? rdata : 32'h00000000;
			end
			if (wr_go) begin
				case (idx)
					`ACEM_IDX_SPEED: begin
						speed_q <= pwdata_in[1:0];
					end
					`ACEM_IDX_CYC_MSB: begin
						cycles_q[15:8] <= pwdata_in[7:0];
					end
					`ACEM_IDX_CYC_LSB: begin
						cycles_q[7:0] <= pwdata_in[7:0];
					end
					`ACEM_IDX_CTRL: begin
						ctrl_q <= pwdata_in[6:0];
					end
					default: begin
						ctrl_q <= ctrl_q;
					end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// ### design/acem_defines.vh
/*
 * Constants of the audio clock error monitor: register offsets, field positions,
 * reset values and timing figures.
 * Assumes it is included by bare name from the design files of the block.
 */
`ifndef ACEM_DEFINES_VH
`define ACEM_DEFINES_VH

// Register indexes; the byte address on the bus is four times the index.
`define ACEM_IDX_STATUS 8'h04
`define ACEM_IDX_SPEED 8'h22
`define ACEM_IDX_CYC_MSB 8'h23
`define ACEM_IDX_CYC_LSB 8'h24
`define ACEM_IDX_CTRL 8'h25
`define ACEM_IDX_FAULT 8'h26

// Fields of the detector ignore control register, and the lock flag of the status register.
`define ACEM_BIT_IGN_RATE 6
`define ACEM_BIT_IGN_BITCLK 5
`define ACEM_BIT_IGN_SYSRATIO 4
`define ACEM_BIT_IGN_HALT 3
`define ACEM_BIT_IGN_MISSING 2
`define ACEM_BIT_AUTOSET_DIS 1
`define ACEM_BIT_IGN_PLL 0
`define ACEM_BIT_PLL_LOCK 4

// Reset values.
`define ACEM_RST_CTRL 7'h00
`define ACEM_RST_SPEED 2'h0
`define ACEM_RST_CYC 16'h0100

// Timing figures.
`define ACEM_CLK_HZ 25000000
`define ACEM_FS_MAX_HZ 384000
`define ACEM_FS_MIN_HZ 8000
`define ACEM_FS_SINGLE_HZ 48000
`define ACEM_FS_DOUBLE_HZ 96000
`define ACEM_FS_QUAD_HZ 192000
`define ACEM_HALT_TIME_NS 4000
`define ACEM_MISSING_TIME_NS 8000
`define ACEM_CLK_PERIOD_NS 40
`define ACEM_BCK_RATIO_MIN 32
`define ACEM_BCK_RATIO_MAX 256
`define ACEM_RATIO_TOL 2

`endif

// ### design/acem_idle_timer.v
/*
 * Idle timer: reports when a condition has held for a number of clock cycles.
 * Assumes the condition input is synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module acem_idle_timer #(
	parameter LIMIT = 100,
	parameter W = 12
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire cond_in,
	output reg idle_out
);

	reg [W-1:0] cnt_q;

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_q <= {W{1'b0}};
			idle_out <= 1'b0;
		end else begin
			if (!cond_in) begin
				cnt_q <= {W{1'b0}};
			end else if (cnt_q < LIMIT[W-1:0]) begin
				cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
			end
			idle_out <= cond_in && (cnt_q >= LIMIT[W-1:0]);
		end
	end

endmodule
`default_nettype wire

// ### design/acem_ratio_meter.v
/*
 * Ratio meter: counts rising edges of a clock-like input within each frame.
 * Assumes frame_edge_in is a one-cycle pulse and sig_in is synchronous to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none

module acem_ratio_meter #(
	parameter W = 10
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire frame_edge_in,
	input wire sig_in,
	output reg [W-1:0] count_out,
	output reg done_out
);

	reg sig_q;
	reg [W-1:0] cnt_q;
	wire rise;
	wire [W-1:0] inc;

	assign rise = sig_in & ~sig_q;
	assign inc = {{(W-1){1'b0}}, rise};

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sig_q <= 1'b0;
			cnt_q <= {W{1'b0}};
			count_out <= {W{1'b0}};
			done_out <= 1'b0;
		end else begin
			sig_q <= sig_in;
			done_out <= frame_edge_in;
			if (frame_edge_in) begin
				count_out <= cnt_q;
				cnt_q <= inc;
			end else if (cnt_q != {W{1'b1}}) begin
				cnt_q <= cnt_q + inc;
			end
		end
	end

endmodule
`default_nettype wire

// ### verification/acem_audio_src.sv
/*
 * Audio source model: frame, bit and system clocks made from the main clock.
 * Assumes a frame of 2*FH clock cycles and nonzero half periods for bit and system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module acem_audio_src #(
	parameter int FH = 64
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] bh_in,
	input wire logic [7:0] sh_in,
	input wire logic [1:0] mode_in,
	input wire logic sys_stop_in,
	output logic frame_clock_out,
	output logic bit_clock_out,
	output logic sys_clock_out
);
	int cnt;
	// Mode 1 holds the frame clock high, mode 2 holds frame and bit clock low.
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= 0;
			frame_clock_out <= 1'h0;
			bit_clock_out <= 1'h0;
			sys_clock_out <= 1'h0;
		end else begin
			cnt <= (cnt + 1) % (2 * FH);
			frame_clock_out <= (mode_in == 2'h1) || (mode_in == 2'h0 && cnt >= FH);
			bit_clock_out <= (mode_in != 2'h2) && ((cnt / bh_in) % 2 == 1);
			if (!sys_stop_in)
				sys_clock_out <= (cnt / sh_in) % 2 == 1;
		end
	end
endmodule
`default_nettype wire

// ### verification/acem_chk.sv
/*
 * Checker of the audio clock error monitor, bound to its top module.
 * Assumes one clock domain and a shadow of the control register kept from APB writes.
 */
`timescale 1ns/1ps
`default_nettype none
module acem_chk (
	input wire clk_in,
	input wire rst_n_in,
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	input wire frame_clock_in,
	input wire bit_clock_in,
	input wire sys_clock_in,
	input wire pll_locked_in,
	input wire [31:0] prdata_out,
	input wire pready_out,
	input wire clock_error_out,
	input wire powerdown_out,
	input wire autoset_active_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	logic [6:0] ign_q;
	logic [3:0] age_q;
	logic [7:0] low_q;
	logic [7:0] halt_q;
	logic sys_q;
	wire ctrl_wr = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h094;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ign_q <= 7'h00;
			age_q <= 4'hf;
			low_q <= 8'h00;
			halt_q <= 8'h00;
			sys_q <= 1'h0;
		end else begin
			if (ctrl_wr)
				ign_q <= pwdata_in[6:0];
			age_q <= ctrl_wr ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
			low_q <= (frame_clock_in || bit_clock_in) ? 8'h00 : low_q + {7'h0, low_q != 8'hff};
			halt_q <= (sys_clock_in != sys_q) ? 8'h00 : halt_q + {7'h0, halt_q != 8'hff};
			sys_q <= sys_clock_in;
		end
	end
	sequence s_setup;
		psel_in && !penable_in ##1 psel_in && penable_in;
	endsequence
	sequence s_stat_rd;
		psel_in && penable_in && pready_out && !pwrite_in && paddr_in == 12'h010
			&& pll_locked_in == $past(pll_locked_in, 4);
	endsequence
	pready_wait_a: assert property (s_setup |=> pready_out)
		else $error("no answer after one wait");
	reset_values_a: assert property (!$past(rst_n_in) |-> autoset_active_out && !clock_error_out && !powerdown_out)
		else $error("outputs not at reset values");
	autoset_follow_a: assert property ($stable(ign_q[1]) [*3] |-> autoset_active_out == !ign_q[1])
		else $error("autoset flag wrong");
	missing_low_a: assert property ($rose(powerdown_out) |-> low_q > 8'd150)
		else $error("powerdown without low clocks");
	missing_mask_a: assert property ($rose(powerdown_out) |-> !ign_q[2])
		else $error("powerdown while ignored");
	halt_error_a: assert property (halt_q > 8'd110 && age_q > 4'd4 && !ign_q[3] |-> clock_error_out)
		else $error("halt without clock error");
	pll_error_a: assert property ($fell(pll_locked_in) && age_q > 4'd3 && !ign_q[0] |-> ##[1:3] clock_error_out)
		else $error("unlock without clock error");
	all_masked_a: assert property (ign_q[6:3] == 4'hf && ign_q[0] && age_q > 4'd4 |-> !clock_error_out)
		else $error("clock error while all ignored");
	status_lock_a: assert property (s_stat_rd |-> prdata_out[4] == pll_locked_in)
		else $error("lock flag wrong");
endmodule
bind acem_top acem_chk i_acem_chk (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
	.frame_clock_in(frame_clock_in), .bit_clock_in(bit_clock_in), .sys_clock_in(sys_clock_in),
	.pll_locked_in(pll_locked_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.clock_error_out(clock_error_out), .powerdown_out(powerdown_out), .autoset_active_out(autoset_active_out));
`default_nettype wire

// ### verification/acem_tb.sv
/*
 * Self-checking testbench of the audio clock error monitor.
 * Assumes the audio source model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench;
	logic clk_in = 1'h0;
	logic rst_n_in = 1'h0;
	logic psel_in = 1'h0;
	logic penable_in = 1'h0;
	logic pwrite_in = 1'h0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0;
	logic pll_locked_in = 1'h1;
	logic [18:0] cfg = 19'h00808;
	logic [31:0] rdat;
	logic rerr;
	int error_cnt = 0;
	int num_checks = 0;
	wire frame_clk, bit_clk, sys_clk;
	wire [31:0] prdata_out;
	wire pready_out, pslverr_out, clock_error_out, powerdown_out, autoset_active_out;
	wire [1:0] speed_sel_out;
	wire [15:0] frame_cycles_out;
	always #20 clk_in = ~clk_in;
	acem_top i_acem_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .frame_clock_in(frame_clk),
		.bit_clock_in(bit_clk), .sys_clock_in(sys_clk), .pll_locked_in(pll_locked_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .clock_error_out(clock_error_out),
		.powerdown_out(powerdown_out), .autoset_active_out(autoset_active_out), .speed_sel_out(speed_sel_out),
		.frame_cycles_out(frame_cycles_out));
	acem_audio_src i_acem_audio_src (.clk_in(clk_in), .rst_n_in(rst_n_in), .bh_in(cfg[18:11]), .sh_in(cfg[10:3]),
		.mode_in(cfg[2:1]), .sys_stop_in(cfg[0]), .frame_clock_out(frame_clk), .bit_clock_out(bit_clk),
		.sys_clock_out(sys_clk));
	task automatic test_done;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_in);
		psel_in <= 1'h1;
		penable_in <= 1'h0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'h1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'h1 && n < 20);
		rdat = prdata_out;
		rerr = pslverr_out;
		psel_in <= 1'h0;
		penable_in <= 1'h0;
		if (pready_out !== 1'h1) begin
			error_cnt++;
			test_done();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
		apb(1'h0, a, 32'h0);
		`CHK({rerr, rdat}, {err, exp})
	endtask
	task automatic t_reset;
		rd(12'h094, 32'h0, 1'h0);
		`CHK({autoset_active_out, powerdown_out}, 2'h2)
		rd(12'h0fc, 32'h0, 1'h1);
		rd(12'h096, 32'h0, 1'h1);
		apb(1'h1, 12'h094, 32'hff);
		rd(12'h094, 32'h7f, 1'h0);
		`CHK(autoset_active_out, 1'h0)
		apb(1'h1, 12'h094, 32'h0);
	endtask
	task automatic t_auto;
		repeat (1000) @(posedge clk_in);
		`CHK(clock_error_out, 1'h0)
		`CHK({speed_sel_out, frame_cycles_out}, {2'h3, 16'h0080})
		apb(1'h1, 12'h088, 32'h1);
		apb(1'h1, 12'h08c, 32'h2);
		apb(1'h1, 12'h090, 32'h34);
		repeat (300) @(posedge clk_in);
		`CHK({speed_sel_out, frame_cycles_out}, {2'h3, 16'h0080})
		apb(1'h1, 12'h094, 32'h2);
		repeat (4) @(posedge clk_in);
		`CHK({autoset_active_out, speed_sel_out, frame_cycles_out}, {1'h0, 2'h1, 16'h0234})
		apb(1'h1, 12'h094, 32'h0);
	endtask
	// Raises one fault with its ignore bit clear, then sets the bit and returns to good clocks.
	task automatic t_fault(input logic [18:0] c, input logic pll, input logic [6:0] base, input logic [6:0] ign,
		input logic [6:0] flt);
		cfg <= c;
		pll_locked_in <= pll;
		apb(1'h1, 12'h094, {25'h0, base});
		repeat (4000) @(posedge clk_in);
		`CHK({clock_error_out, powerdown_out}, 2'h2)
		rd(12'h098, {25'h0, flt}, 1'h0);
		apb(1'h1, 12'h094, {25'h0, base | ign});
		repeat (20) @(posedge clk_in);
		`CHK(clock_error_out, 1'h0)
		apb(1'h0, 12'h010, 32'h0);
		`CHK(rdat[4], pll)
		cfg <= 19'h00808;
		pll_locked_in <= 1'h1;
		apb(1'h1, 12'h094, 32'h0);
		repeat (1000) @(posedge clk_in);
		`CHK(clock_error_out, 1'h0)
	endtask
	task automatic t_missing;
		apb(1'h1, 12'h094, 32'h4);
		cfg <= 19'h0080c;
		repeat (300) @(posedge clk_in);
		`CHK(powerdown_out, 1'h0)
		apb(1'h1, 12'h094, 32'h0);
		repeat (10) @(posedge clk_in);
		`CHK(powerdown_out, 1'h1)
		cfg <= 19'h00808;
		repeat (20) @(posedge clk_in);
		`CHK(powerdown_out, 1'h0)
	endtask
	initial begin
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'h1;
		t_reset();
		t_auto();
		t_fault(19'h02008, 1'h1, 7'h00, 7'h20, 7'h42);
		t_fault(19'h00810, 1'h1, 7'h00, 7'h10, 7'h44);
		t_fault(19'h00809, 1'h1, 7'h10, 7'h08, 7'h4c);
		t_fault(19'h0080a, 1'h1, 7'h30, 7'h40, 7'h47);
		t_fault(19'h00808, 1'h0, 7'h00, 7'h01, 7'h60);
		t_missing();
		test_done();
	end
endmodule
`default_nettype wire
